/* File: hw/pwm_port_pkg.sv */
// shared constants for the ten-port level / pwm control block
`default_nettype none
package pwm_port_pkg;
    localparam int NUM_PORTS = 10;
    localparam int CODE_W = 8;
    localparam int ADDR_W = 7;
    localparam int UNITS_W = 5;        // sink current in units of a half step
    localparam int GLOBAL_W = 3;

    // register addresses
    localparam logic [6:0] ADDR_PORT_LAST = 7'h09;
    localparam logic [6:0] ADDR_GROUP_ALL = 7'h0A;
    localparam logic [6:0] ADDR_GROUP_LOW = 7'h0B;
    localparam logic [6:0] ADDR_GROUP_HIGH = 7'h0C;
    localparam logic [6:0] ADDR_GROUP_PAIR = 7'h0D;
    localparam logic [6:0] ADDR_PIN_LOW = 7'h0E;
    localparam logic [6:0] ADDR_PIN_HIGH = 7'h0F;

    // port ranges touched by the group writes, and the port each reads back
    localparam int LOW_QUAD_FIRST = 0;
    localparam int LOW_QUAD_LAST = 3;
    localparam int HIGH_QUAD_FIRST = 4;
    localparam int HIGH_QUAD_LAST = 7;
    localparam int PAIR_FIRST = 8;
    localparam int PAIR_LAST = 9;

    // port codes
    localparam logic [7:0] CODE_DRIVE_LOW = 8'h00;
    localparam logic [7:0] CODE_INPUT = 8'h01;
    localparam logic [7:0] CODE_STATIC_SINK = 8'h02;
    localparam logic [7:0] CODE_PWM_MIN = 8'h03;
    localparam logic [7:0] CODE_PWM_MAX = 8'hFE;
    localparam logic [7:0] CODE_HIGH_Z = 8'hFF;

    // values after reset
    localparam logic [7:0] PORT_CODE_RST = 8'hFF;  // all ports released
    localparam logic [7:0] PHASE_RST = 8'h00;
    localparam logic [7:0] RDATA_RST = 8'h00;
    localparam logic SRC_EXT_RST_VARIANT_A = 1'b0; // internal oscillator
    localparam logic SRC_EXT_RST_VARIANT_B = 1'b1; // external clock pin

    // internal oscillator rate, kept for reference by the neighbour divider
    localparam int INT_OSC_HZ = 32000;
endpackage
`default_nettype wire

/* File: hw/pin_sync.sv */
// two flip-flop synchroniser for pins arriving from outside the clock domain
`default_nettype none
module pin_sync #(
    parameter int W = 1
) (
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic ce,
    // pin side and synchronised side
    input wire logic [W-1:0] pin_in,
    output logic [W-1:0] pin_sync_out
);
    typedef struct packed {
        logic [W-1:0] meta;   // first stage, read only by the second
        logic [W-1:0] safe;   // second stage, free for logic
    } sync_state_t;

    sync_state_t st_reg;
    sync_state_t st_next;

    // shift the pin through both stages
    always_comb begin
        st_next = st_reg;
        st_next.meta = pin_in;
        st_next.safe = st_reg.meta;
    end

    // clock enable low freezes both stages
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            st_reg <= '0;
        end else if (ce) begin
            st_reg <= st_next;
        end
    end

    assign pin_sync_out = st_reg.safe;
endmodule
`default_nettype wire

/* File: hw/port_cell.sv */
// per-port decode of the 8-bit code into pin drive and sink current
`default_nettype none
module port_cell (
    // port setting
    input wire logic [7:0] code,
    input wire logic full_sel,
    input wire logic [2:0] global_level,
    // shared timing and mode
    input wire logic [7:0] phase,
    input wire logic shutdown,
    // decoded behaviour
    output logic drive_low,
    output logic input_en,
    output logic [4:0] sink_units
);
    logic sink_on;
    logic [4:0] level_units;

    // half step count: global level plus one, doubled for full current
    always_comb begin
        level_units = 5'(({2'h0, global_level} + 5'h01) << full_sel);
    end

    // choose behaviour from the code; shutdown only kills the sinks
    always_comb begin
        drive_low = 1'b0;
        input_en = 1'b0;
        sink_on = 1'b0;
        if (code == pwm_port_pkg::CODE_DRIVE_LOW) begin
            drive_low = 1'b1;
        end else if (code == pwm_port_pkg::CODE_INPUT) begin
            input_en = 1'b1;
        end else if (code == pwm_port_pkg::CODE_STATIC_SINK) begin
            sink_on = !shutdown;
        end else if (code != pwm_port_pkg::CODE_HIGH_Z) begin
            // duty is code/256: on while the phase is below the code
            sink_on = !shutdown && (phase < code);
        end
        // code 0xFF leaves everything off
        sink_units = sink_on ? level_units : 5'h00;
    end
endmodule
`default_nettype wire

/* File: hw/pwm_port_ctrl.sv */
// ten-port level / pwm control block with group writes and pin readback
`default_nettype none
module pwm_port_ctrl #(
    parameter int NUM_PORTS = pwm_port_pkg::NUM_PORTS,
    parameter bit VARIANT_EXT_DEFAULT = 1'b0
) (
    // clock, reset, enable
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic ce,
    // register port from the serial protocol engine
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [6:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    output logic [7:0] reg_rdata,
    output logic reg_rvalid,
    // settings from neighbouring configuration and current registers
    input wire logic shutdown,
    input wire logic src_sel_wr,
    input wire logic src_sel_ext,
    input wire logic [9:0] full_sel,
    input wire logic [2:0] global_level,
    // pwm timebases
    input wire logic int_osc_tick,
    input wire logic ext_osc_pin,
    output logic pwm_src_ext,
    // open-drain port pins and sink control
    input wire logic [9:0] io_port_i,
    output logic [9:0] io_port_o,
    output logic [9:0] io_port_oe,
    output logic [9:0][4:0] sink_units
);
    ////////////////////////////////////////////////////////////////////////
    // state

    typedef struct packed {
        logic [9:0][7:0] code;     // port code registers
        logic [7:0] phase;         // pwm step within the 256-step period
        logic src_ext;             // pwm clock from external pin
        logic ext_prev;            // last synchronised external clock level
        logic [7:0] rdata;         // read answer
        logic rvalid;              // read answer strobe
        logic [9:0] pin_o;         // open-drain data, always low
        logic [9:0] pin_oe;        // low drive enables
        logic [9:0][4:0] units;    // sink current per port
    } ctrl_state_t;

    localparam logic SRC_EXT_RST = VARIANT_EXT_DEFAULT ?
        pwm_port_pkg::SRC_EXT_RST_VARIANT_B : pwm_port_pkg::SRC_EXT_RST_VARIANT_A;

    ctrl_state_t st_reg;
    ctrl_state_t st_next;

    logic [9:0] pins_sync;         // pins after two flops
    logic ext_osc_sync;            // external clock after two flops
    logic [9:0] cell_drive_low;
    logic [9:0] cell_input_en;
    logic [9:0][4:0] cell_units;
    logic ext_rise;
    logic pwm_tick;
    logic [9:0] wr_hit;            // ports loaded by this write
    logic [9:0] readback;          // pin levels gated by input mode

    ////////////////////////////////////////////////////////////////////////
    // synchronisers

    // port pins come from outside the clock domain
    pin_sync #(.W(10)) u_pin_sync (
        .clk_sys(clk_sys),
        .rst(rst),
        .ce(ce),
        .pin_in(io_port_i),
        .pin_sync_out(pins_sync)
    );

    // the external pwm clock is slow, so it is sampled as a level
    pin_sync #(.W(1)) u_osc_sync (
        .clk_sys(clk_sys),
        .rst(rst),
        .ce(ce),
        .pin_in(ext_osc_pin),
        .pin_sync_out(ext_osc_sync)
    );

    ////////////////////////////////////////////////////////////////////////
    // per-port decode

    for (genvar i = 0; i < 10; i++) begin : g_cell
        port_cell u_cell (
            .code(st_reg.code[i]),
            .full_sel(full_sel[i]),
            .global_level(global_level),
            .phase(st_reg.phase),
            .shutdown(shutdown),
            .drive_low(cell_drive_low[i]),
            .input_en(cell_input_en[i]),
            .sink_units(cell_units[i])
        );
    end

    ////////////////////////////////////////////////////////////////////////
    // pwm timebase

    // one step per rising edge of the chosen clock; the internal tick is
    // already a one-cycle pulse from the oscillator divider
    always_comb begin
        ext_rise = ext_osc_sync && !st_reg.ext_prev;
        pwm_tick = st_reg.src_ext ? ext_rise : int_osc_tick;
    end

    ////////////////////////////////////////////////////////////////////////
    // write decode and readback gating

    // a write may land on one port or on a whole group
    always_comb begin
        wr_hit = '0;
        for (int i = 0; i < 10; i++) begin
            if (reg_addr == 7'(i)) begin
                wr_hit[i] = 1'b1;
            end
            if (reg_addr == pwm_port_pkg::ADDR_GROUP_ALL) begin
                wr_hit[i] = 1'b1;
            end
            if (reg_addr == pwm_port_pkg::ADDR_GROUP_LOW &&
                i >= pwm_port_pkg::LOW_QUAD_FIRST &&
                i <= pwm_port_pkg::LOW_QUAD_LAST) begin
                wr_hit[i] = 1'b1;
            end
            if (reg_addr == pwm_port_pkg::ADDR_GROUP_HIGH &&
                i >= pwm_port_pkg::HIGH_QUAD_FIRST &&
                i <= pwm_port_pkg::HIGH_QUAD_LAST) begin
                wr_hit[i] = 1'b1;
            end
            if (reg_addr == pwm_port_pkg::ADDR_GROUP_PAIR &&
                i >= pwm_port_pkg::PAIR_FIRST &&
                i <= pwm_port_pkg::PAIR_LAST) begin
                wr_hit[i] = 1'b1;
            end
        end
        // readback addresses match nothing here, so writes there fall away
        if (!reg_wr) begin
            wr_hit = '0;
        end
    end

    // only ports set as logic inputs show their pin level
    always_comb begin
        readback = pins_sync & cell_input_en;
    end

    ////////////////////////////////////////////////////////////////////////
    // next state

    always_comb begin
        st_next = st_reg;
        st_next.ext_prev = ext_osc_sync;
        st_next.rvalid = 1'b0;

        // source select is written by the configuration register next door
        if (src_sel_wr) begin
            st_next.src_ext = src_sel_ext;
        end

        // 8-bit counter wraps every 256 steps
        if (pwm_tick) begin
            st_next.phase = 8'(st_reg.phase + 8'h01);
        end

        // port code loads
        for (int i = 0; i < 10; i++) begin
            if (wr_hit[i]) begin
                st_next.code[i] = reg_wdata;
            end
        end

        // read answer, one cycle after the strobe; unmapped reads give zero
        if (reg_rd) begin
            st_next.rvalid = 1'b1;
            st_next.rdata = 8'h00;
            if (reg_addr <= pwm_port_pkg::ADDR_PORT_LAST) begin
                st_next.rdata = st_reg.code[reg_addr[3:0]];
            end else if (reg_addr == pwm_port_pkg::ADDR_GROUP_ALL ||
                         reg_addr == pwm_port_pkg::ADDR_GROUP_LOW) begin
                st_next.rdata = st_reg.code[pwm_port_pkg::LOW_QUAD_FIRST];
            end else if (reg_addr == pwm_port_pkg::ADDR_GROUP_HIGH) begin
                st_next.rdata = st_reg.code[pwm_port_pkg::HIGH_QUAD_FIRST];
            end else if (reg_addr == pwm_port_pkg::ADDR_GROUP_PAIR) begin
                st_next.rdata = st_reg.code[pwm_port_pkg::PAIR_FIRST];
            end else if (reg_addr == pwm_port_pkg::ADDR_PIN_LOW) begin
                st_next.rdata = readback[7:0];
            end else if (reg_addr == pwm_port_pkg::ADDR_PIN_HIGH) begin
                st_next.rdata = {6'h00, readback[9:8]};
            end
        end

        // pin and sink outputs, registered so the pads see clean levels
        st_next.pin_o = '0;
        st_next.pin_oe = cell_drive_low;
        st_next.units = cell_units;
    end

    ////////////////////////////////////////////////////////////////////////
    // state register

    // ports come up released; clock source per variant
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            st_reg.code <= {10{pwm_port_pkg::PORT_CODE_RST}};
            st_reg.phase <= pwm_port_pkg::PHASE_RST;
            st_reg.src_ext <= SRC_EXT_RST;
            st_reg.ext_prev <= 1'b0;
            st_reg.rdata <= pwm_port_pkg::RDATA_RST;
            st_reg.rvalid <= 1'b0;
            st_reg.pin_o <= '0;
            st_reg.pin_oe <= '0;
            st_reg.units <= '0;
        end else if (ce) begin
            st_reg <= st_next;
        end
    end

    // outputs
    assign reg_rdata = st_reg.rdata;
    assign reg_rvalid = st_reg.rvalid;
    assign pwm_src_ext = st_reg.src_ext;
    assign io_port_o = st_reg.pin_o;
    assign io_port_oe = st_reg.pin_oe;
    assign sink_units = st_reg.units;

    ////////////////////////////////////////////////////////////////////////
    // assertions

    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (rst);

    AST_PORT_WRITE: assert property (
        (ce && reg_wr && reg_addr <= pwm_port_pkg::ADDR_PORT_LAST)
        |=> st_reg.code[$past(reg_addr[3:0])] == $past(reg_wdata))
        else $error("single port write not stored");

    AST_DRIVE_LOW: assert property (
        (ce && st_reg.code[0] == pwm_port_pkg::CODE_DRIVE_LOW)
        |=> io_port_oe[0] && !io_port_o[0] && sink_units[0] == 5'h00)
        else $error("code 0x00 does not drive low");

    AST_INPUT_FREE: assert property (
        (ce && st_reg.code[1] == pwm_port_pkg::CODE_INPUT)
        |=> !io_port_oe[1] && sink_units[1] == 5'h00)
        else $error("input port is driven");

    AST_STATIC_SINK: assert property (
        (ce && st_reg.code[2] == pwm_port_pkg::CODE_STATIC_SINK && !shutdown)
        |=> sink_units[2] != 5'h00)
        else $error("static sink is off");

    AST_PWM_OFF_PHASE: assert property (
        (ce && st_reg.code[3] >= pwm_port_pkg::CODE_PWM_MIN &&
         st_reg.code[3] <= pwm_port_pkg::CODE_PWM_MAX &&
         (st_reg.phase >= st_reg.code[3] || shutdown))
        |=> sink_units[3] == 5'h00)
        else $error("pwm sink on outside duty window");

    AST_HIGH_Z: assert property (
        (ce && st_reg.code[4] == pwm_port_pkg::CODE_HIGH_Z)
        |=> !io_port_oe[4] && sink_units[4] == 5'h00)
        else $error("high impedance port not released");

    AST_FULL_CURRENT: assert property (
        (ce && st_reg.code[5] == pwm_port_pkg::CODE_STATIC_SINK && !shutdown &&
         full_sel[5] && global_level == 3'h7)
        |=> sink_units[5] == 5'h10)
        else $error("full current at top level wrong");

    AST_GROUP_ALL: assert property (
        (ce && reg_wr && reg_addr == pwm_port_pkg::ADDR_GROUP_ALL)
        |=> st_reg.code == {10{$past(reg_wdata)}})
        else $error("group write to all ports failed");

    AST_GROUP_HIGH: assert property (
        (ce && reg_wr && reg_addr == pwm_port_pkg::ADDR_GROUP_HIGH)
        |=> st_reg.code[7:4] == {4{$past(reg_wdata)}} &&
            st_reg.code[3:0] == $past(st_reg.code[3:0]))
        else $error("group write to ports 4-7 wrong");

    AST_PIN_HIGH_READ: assert property (
        (ce && reg_rd && reg_addr == pwm_port_pkg::ADDR_PIN_HIGH)
        |=> reg_rvalid && reg_rdata[7:2] == 6'h00)
        else $error("upper pin readback has stray bits");

    AST_READBACK_GATE: assert property (
        (ce && reg_rd && reg_addr == pwm_port_pkg::ADDR_PIN_LOW &&
         st_reg.code[0] != pwm_port_pkg::CODE_INPUT)
        |=> reg_rdata[0] == 1'b0)
        else $error("non-input port shows a pin level");

    AST_READBACK_RO: assert property (
        (ce && reg_wr && (reg_addr == pwm_port_pkg::ADDR_PIN_LOW ||
                          reg_addr == pwm_port_pkg::ADDR_PIN_HIGH))
        |=> st_reg.code == $past(st_reg.code))
        else $error("write to readback changed a port");

    AST_PHASE_STEP: assert property (
        (ce && pwm_tick) |=> st_reg.phase == 8'($past(st_reg.phase) + 8'h01))
        else $error("pwm phase did not advance");

    AST_READ_ANSWER: assert property (
        (ce && reg_rd) |=> reg_rvalid)
        else $error("read strobe not answered");

    AST_READ_ONE_SHOT: assert property (
        (ce && !reg_rd) |=> !reg_rvalid)
        else $error("read answer without a read strobe");

    AST_PWM_ON_PHASE: assert property (
        (ce && st_reg.code[3] >= pwm_port_pkg::CODE_PWM_MIN &&
         st_reg.code[3] <= pwm_port_pkg::CODE_PWM_MAX &&
         st_reg.phase < st_reg.code[3] && !shutdown)
        |=> sink_units[3] != 5'h00)
        else $error("pwm sink off inside duty window");

    AST_SRC_SELECT: assert property (
        (ce && src_sel_wr) |=> pwm_src_ext == $past(src_sel_ext))
        else $error("pwm clock source not loaded");

    AST_GROUP_LOW: assert property (
        (ce && reg_wr && reg_addr == pwm_port_pkg::ADDR_GROUP_LOW)
        |=> st_reg.code[3:0] == {4{$past(reg_wdata)}} &&
            st_reg.code[9:4] == $past(st_reg.code[9:4]))
        else $error("group write to ports 0-3 wrong");

    AST_GROUP_PAIR: assert property (
        (ce && reg_wr && reg_addr == pwm_port_pkg::ADDR_GROUP_PAIR)
        |=> st_reg.code[9:8] == {2{$past(reg_wdata)}} &&
            st_reg.code[7:0] == $past(st_reg.code[7:0]))
        else $error("group write to ports 8-9 wrong");

    AST_PIN_LOW_READ: assert property (
        (ce && reg_rd && reg_addr == pwm_port_pkg::ADDR_PIN_LOW)
        |=> reg_rvalid && reg_rdata == $past(readback[7:0]))
        else $error("lower pin readback wrong");

    COV_GROUP_WRITE: cover property (
        ce && reg_wr && reg_addr == pwm_port_pkg::ADDR_GROUP_ALL);
    COV_PWM_EDGE: cover property (
        ce && st_reg.code[3] == pwm_port_pkg::CODE_PWM_MIN && sink_units[3] != 5'h00
        ##1 sink_units[3] == 5'h00);
    COV_INPUT_READ: cover property (
        ce && reg_rd && reg_addr == pwm_port_pkg::ADDR_PIN_LOW && readback[1]);
    COV_EXT_CLOCK: cover property (ce && st_reg.src_ext && ext_rise);
endmodule
`default_nettype wire

/* File: dv/reg_host_model.sv */
// register-port master standing in for the microprocessor behind the serial engine
`default_nettype none
module reg_host_model (
    // clock
    input wire logic clk_sys,
    // requests toward the block
    output logic reg_wr,
    output logic reg_rd,
    output logic [6:0] reg_addr,
    output logic [7:0] reg_wdata,
    // answers from the block
    input wire logic [7:0] reg_rdata,
    input wire logic reg_rvalid
);
    timeunit 1ns;
    timeprecision 100ps;
    bit timed_out = 1'b0; // last read never answered

    ////////////////////////////////////////////////////////////////////////
    // idle bus at time zero
    initial begin
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_addr = 7'h00;
        reg_wdata = 8'h00;
    end

    ////////////////////////////////////////////////////////////////////////
    // one write: strobe held for exactly one sampling edge
    task automatic write_reg(input logic [6:0] addr, input logic [7:0] data);
        @(posedge clk_sys);
        #1;
        reg_addr = addr;
        reg_wdata = data;
        reg_wr = 1'b1;
        @(posedge clk_sys);
        #1;
        reg_wr = 1'b0;
        // released lines show no stale value, so a late sample cannot pass by luck
        reg_addr = ~addr;
        reg_wdata = ~data;
    endtask

    // one read: answer is due one edge after the strobe, a few more are tolerated
    task automatic read_reg(input logic [6:0] addr, output logic [7:0] data);
        @(posedge clk_sys);
        #1;
        reg_addr = addr;
        reg_rd = 1'b1;
        @(posedge clk_sys);
        #1;
        reg_rd = 1'b0;
        reg_addr = ~addr;
        for (int k = 0; k < 4 && reg_rvalid !== 1'b1; k++) begin
            @(posedge clk_sys);
            #1;
        end
        timed_out = (reg_rvalid !== 1'b1);
        data = reg_rdata;
    endtask
endmodule
`default_nettype wire

/* File: dv/pwm_port_ctrl_test.sv */
// self-checking bench for the ten-port level / pwm control block
`default_nettype none
module pwm_port_ctrl_test;
    timeunit 1ns;
    timeprecision 100ps;
    logic clk_sys, rst, ce, shutdown, src_sel_wr, src_sel_ext;
    logic int_osc_tick, ext_osc_pin, pwm_src_ext, reg_wr, reg_rd, reg_rvalid;
    logic [9:0] full_sel, ext_lvl, pin, io_port_o, io_port_oe;
    logic [2:0] global_level;
    logic [9:0][4:0] sink_units;
    logic [6:0] reg_addr;
    logic [7:0] reg_wdata, reg_rdata, d, c;
    logic [7:0] shadow [10]; // expected port codes
    logic [7:0] tbl [4] = '{8'h00, 8'h01, 8'h02, 8'hFF}; // static codes
    int n_errors = 0;
    int comparisons = 0;
    int cnt, pp;
    // open-drain pins: follow the random outside level ext_lvl unless the port pulls low
    assign pin = (io_port_oe & io_port_o) | (~io_port_oe & ext_lvl);

    ////////////////////////////////////////////////////////////////////////
    // block and host
    pwm_port_ctrl #(.VARIANT_EXT_DEFAULT(1'b0)) dut (
        .clk_sys(clk_sys), .rst(rst), .ce(ce), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .reg_rvalid(reg_rvalid), .shutdown(shutdown), .src_sel_wr(src_sel_wr),
        .src_sel_ext(src_sel_ext), .full_sel(full_sel), .global_level(global_level),
        .int_osc_tick(int_osc_tick), .ext_osc_pin(ext_osc_pin), .pwm_src_ext(pwm_src_ext),
        .io_port_i(pin), .io_port_o(io_port_o), .io_port_oe(io_port_oe),
        .sink_units(sink_units));
    reg_host_model host (.clk_sys(clk_sys), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .reg_rvalid(reg_rvalid));

    initial begin
        clk_sys = 1'b0;
        forever #2 clk_sys = ~clk_sys;
    end

    ////////////////////////////////////////////////////////////////////////
    // expectations
    function automatic logic [4:0] lvl(input int p);
        logic [4:0] u;
        u = 5'(global_level) + 5'h01; // half current in half-step units
        return full_sel[p] ? u << 1 : u;
    endfunction
    function automatic logic [4:0] exp_sink(input int p);
        return (shadow[p] == 8'h02 && !shutdown) ? lvl(p) : 5'h00;
    endfunction
    function automatic logic [7:0] exp_rd(input logic [6:0] a);
        logic [9:0] m;
        for (int p = 0; p < 10; p++) m[p] = (shadow[p] == 8'h01); // input ports only
        if (a <= 7'h09) return shadow[a];
        if (a <= 7'h0B) return shadow[0];
        if (a == 7'h0C) return shadow[4];
        if (a == 7'h0D) return shadow[8];
        if (a == 7'h0E) return pin[7:0] & m[7:0];
        if (a == 7'h0F) return {6'h00, pin[9:8] & m[9:8]};
        return 8'h00; // unmapped
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // shared tasks
    task automatic print_verdict();
        $display("comparisons %0d errors %0d", comparisons, n_errors);
        if (n_errors == 0 && comparisons > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
        comparisons++;
        if (seen !== exp) begin
            n_errors++;
            $display("ERROR %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic step(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask
    // write and track which codes a group address touches
    task automatic wr(input logic [6:0] a, input logic [7:0] v);
        host.write_reg(a, v);
        for (int p = 0; p < 10; p++) begin
            if (a == 7'(p) || a == 7'h0A || (a == 7'h0B && p < 4) ||
                (a == 7'h0C && p >= 4 && p < 8) || (a == 7'h0D && p >= 8)) shadow[p] = v;
        end
    endtask
    task automatic rd(input logic [6:0] a);
        host.read_reg(a, d);
        if (host.timed_out) begin
            n_errors++;
            print_verdict();
        end else begin
            check("read value", {8'h00, d}, {8'h00, exp_rd(a)});
            step(1);
            check("read strobe width", reg_rvalid, 1'b0);
            check("read data holds", reg_rdata, d);
        end
    endtask
    task automatic src(input logic v);
        src_sel_ext = v;
        src_sel_wr = 1'b1;
        step(1);
        src_sel_wr = 1'b0;
    endtask
    // counts cycles at the port's sink level lvl(p); half is the ext pin toggle spacing, 0 = internal
    task automatic pwm_count(input int p, input int n, input int half);
        cnt = 0;
        for (int i = 0; i < n + 16; i++) begin
            if (half != 0 && i % half == 0) ext_osc_pin = ~ext_osc_pin;
            if (i >= 16 && sink_units[p] === lvl(p)) cnt++;
            step(1);
        end
    endtask

    ////////////////////////////////////////////////////////////////////////
    // main sequence
    initial begin
        void'($urandom(3401));
        rst = 1'b1;
        ce = 1'b1; // run; dropped once near the end
        shutdown = 1'b0;
        src_sel_wr = 1'b0;
        src_sel_ext = 1'b0;
        int_osc_tick = 1'b0;
        ext_osc_pin = 1'b0;
        full_sel = 10'($urandom);
        global_level = 3'($urandom);
        ext_lvl = 10'($urandom);
        for (int p = 0; p < 10; p++) shadow[p] = 8'hFF;
        repeat (8) @(posedge clk_sys);
        #1;
        rst = 1'b0;
        check("source after reset", pwm_src_ext, 1'b0);
        check("pull low after reset", io_port_oe, 10'h000);
        check("sink after reset", |sink_units, 1'b0);
        for (int a = 0; a < 17; a++) rd(7'(a));
        // random writes anywhere, unmapped and read-only places included
        for (int k = 0; k < 60; k++) begin
            wr(7'($urandom_range(16, 0)), 8'($urandom));
            step(4);
            rd(7'($urandom_range(16, 0)));
        end
        // every group and read-only address once, then the whole map
        for (int a = 10; a < 16; a++) begin
            wr(7'(a), 8'($urandom));
            step(4);
            for (int b = 0; b < 16; b++) rd(7'(b));
        end
        // static codes on every port, with and without shutdown
        for (int r = 0; r < 8; r++) begin
            for (int p = 0; p < 10; p++) wr(7'(p), tbl[(p + r) % 4]);
            full_sel = 10'($urandom);
            global_level = 3'($urandom);
            ext_lvl = 10'($urandom);
            shutdown = r[2]; // every port and code meets both shutdown levels
            if (r == 1) begin
                full_sel[5] = 1'b1; // top current on the static sink of port 5
                global_level = 3'h7;
            end
            step(4);
            for (int p = 0; p < 10; p++) begin
                check("pull low", io_port_oe[p], shadow[p] == 8'h00);
                check("pin data", io_port_o[p], 1'b0);
                check("sink", sink_units[p], exp_sink(p));
            end
            rd(7'h0E);
            rd(7'h0F);
        end
        shutdown = 1'b0;
        // pwm duty from both sources; internal tick high steps every cycle, unused if external
        int_osc_tick = 1'b1;
        for (int k = 0; k < 3; k++) begin
            pp = (k == 0) ? 3 : $urandom_range(9, 0);
            c = (k == 0) ? 8'h03 : (k == 1) ? 8'hFE : 8'($urandom_range(253, 4));
            wr(7'(pp), c);
            step(3);
            pwm_count(pp, 256, 0);
            check("internal pwm on cycles", 16'(cnt), {8'h00, c});
            src(1'b1);
            check("source external", pwm_src_ext, 1'b1);
            pwm_count(pp, 1024, 2);
            check("external pwm on cycles", 16'(cnt), {6'h00, c, 2'b00});
            src(1'b0);
            check("source internal", pwm_src_ext, 1'b0);
        end
        // clock enable low: a group write must not land
        ce = 1'b0;
        host.write_reg(7'h0A, ~shadow[0]);
        ce = 1'b1;
        rd(7'h00);
        rd(7'h09);
        print_verdict();
    end
endmodule
`default_nettype wire
